//--- logic/fwd_filter_pkg.sv
// Shared constants of the frame forwarding and filtering block: register map,
// field positions, reset values, ranges and timing counts.
// Assumes a single 100 MHz clock and an AHB-Lite master with 32-bit data.
// Operation
// RQ1 - Known destination goes only to the port stored for it.
// RQ2 - Unknown destination is flooded to every port; the code floods every port except the ingress port.
// RQ3 - Learned entry is removed once idle longer than the aging time.
// RQ4 - Aging time accepts 300 up to 1,000,000 seconds.
// RQ5 - Aging time is 300 seconds after reset.
// RQ6 - Static unicast entries match on MAC address and VLAN together.
// RQ7 - Static unicast type forwards to its port or discards, ignoring port.
// RQ8 - Static multicast entry steers frames from its source MAC to VLAN members.
// RQ9 - Each port of a multicast entry is static, forbidden or free to join.
// RQ10 - Broadcast or multicast above threshold with suppression enabled is dropped.
// RQ11 - Forwarding of that class resumes once the rate is below threshold.
// RQ12 - Storm threshold is in thousands of packets per second, per port group.
// RQ13 - Broadcast and multicast suppression have independent enables.
// RQ14 - Per-port flow-control threshold 2 to 57344 triggers flow control.
// RQ15 - Flow-control threshold acts only where flow control is enabled.
// RQ16 - Each port shows readable dropping and flow-control status flags.
// RQ17 - Route entry holds address, mask, gateway and metric 1 to 15.
// RQ18 - ARP entry maps IP to MAC and names its IP interface.
// RQ19 - Idle counter clears on reference, steps each second, expires past aging.
// RQ20 - Static entries are never aged; only management removes them.
package fwd_filter_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_SEC = 1;
  localparam int unsigned TICK_CYCLES = TICK_SEC * CLK_HZ;
  localparam logic [19:0] AGE_MIN = 20'd300;
  localparam logic [19:0] AGE_MAX = 20'd1000000;
  localparam logic [19:0] AGE_RESET = 20'd300;
  localparam logic [15:0] FC_THR_MIN = 16'd2;
  localparam logic [15:0] FC_THR_MAX = 16'd57344;
  localparam logic [15:0] FC_THR_RESET = 16'd57344;
  localparam logic [15:0] STORM_THR_RESET = 16'd1;
  localparam logic [25:0] KPPS_SCALE = 26'd1000;
  localparam logic [3:0] METRIC_MIN = 4'd1;
  localparam logic [3:0] METRIC_MAX = 4'd15;
  // Register byte offsets.
  localparam logic [11:0] REG_AGE = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_FC_EN = 12'h008;
  localparam logic [11:0] REG_STORM_BASE = 12'h010;
  localparam logic [11:0] REG_FC_THR_BASE = 12'h020;
  localparam logic [11:0] REG_UC_BASE = 12'h040;
  localparam logic [11:0] REG_MC_BASE = 12'h080;
  localparam logic [11:0] REG_TBL_BASE = 12'h100;
  localparam logic [11:0] REG_TBL_END = 12'h140;
  // Field positions.
  localparam int unsigned STORM_BC_EN_BIT = 16;
  localparam int unsigned STORM_MC_EN_BIT = 17;
  localparam int unsigned ENTRY_VALID_BIT = 31;
  localparam int unsigned UC_DISCARD_BIT = 30;
  localparam int unsigned VLAN_LSB = 16;
  localparam int unsigned STATUS_FLOW_LSB = 16;
  // Multicast port membership encodings.
  localparam logic [1:0] MEMBER_OPEN = 2'h0;
  localparam logic [1:0] MEMBER_STATIC = 2'h1;
  localparam logic [1:0] MEMBER_FORBID = 2'h2;
  // Static unicast entry types.
  localparam logic UC_FORWARD_TYPE = 1'b0;
  localparam logic DISCARD_ENTRY_TYPE = 1'b1;
  localparam logic [47:0] BCAST_MAC = 48'hFFFFFFFFFFFF;
  localparam int unsigned MCAST_BIT = 40;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : fwd_filter_pkg

//--- logic/l2_l3_forwarding_filter.sv
// Forwarding decision, address learning and aging, storm control, flow-control
// status, and route/ARP table storage behind an AHB-Lite register slave.
// Assumes frame headers arrive as one-cycle requests synchronous to mclk.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module l2_l3_forwarding_filter
  import fwd_filter_pkg::*;
#(
  parameter int unsigned NPORT = 8,
  parameter int unsigned NGROUP = 2,
  parameter int unsigned NUC = 4,
  parameter int unsigned NMC = 2,
  parameter int unsigned NLRN = 8,
  parameter int unsigned NTBL = 16,
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic [31:0] hrdata, // Read data.
  output logic hresp, // Always OKAY.
  input wire logic frmValid, // Frame header present.
  input wire logic [$clog2(NPORT)-1:0] frmPort, // Ingress port.
  input wire logic [47:0] frmDst, // Destination MAC.
  input wire logic [47:0] frmSrc, // Source MAC.
  input wire logic [11:0] frmVlan, // VLAN of the frame.
  input wire logic [NPORT*16-1:0] portLoad, // Traffic held per port.
  output logic fwdValid, // Decision present.
  output logic [NPORT-1:0] fwdMask, // Egress ports.
  output logic fwdDrop, // Frame discarded.
  output logic [NPORT-1:0] flowActive, // Flow control applied per port.
  output logic [NPORT-1:0] dropActive // Port dropping traffic.
);
  localparam int unsigned PW = $clog2(NPORT);
  localparam int unsigned LW = $clog2(NLRN);
  localparam int unsigned GSZ = NPORT / NGROUP;
  localparam logic [31:0] TICK_LAST = 32'(TICK_LEN - 1);

  typedef struct packed {
    logic [19:0] ageTime;
    logic [NPORT-1:0] fcEn;
    logic [NGROUP-1:0] bcEn;
    logic [NGROUP-1:0] mcEn;
    logic [NGROUP-1:0][15:0] stormThr;
    logic [NPORT-1:0][15:0] fcThr;
    logic [NUC-1:0][47:0] ucMac;
    logic [NUC-1:0][11:0] ucVlan;
    logic [NUC-1:0][PW-1:0] ucPort;
    logic [NUC-1:0] ucDiscard;
    logic [NUC-1:0] ucValid;
    logic [NMC-1:0][47:0] mcMac;
    logic [NMC-1:0][11:0] mcVlan;
    logic [NMC-1:0][NPORT-1:0][1:0] mcState;
    logic [NMC-1:0][NPORT-1:0] mcJoin;
    logic [NMC-1:0] mcValid;
    logic [NLRN-1:0][47:0] lnMac;
    logic [NLRN-1:0][PW-1:0] lnPort;
    logic [NLRN-1:0][19:0] lnIdle;
    logic [NLRN-1:0] lnValid;
    logic [LW-1:0] lnVictim;
    logic [NTBL-1:0][31:0] tbl;
    logic [NPORT-1:0][25:0] bcCnt;
    logic [NPORT-1:0][25:0] mcCnt;
    logic [NPORT-1:0] bcStorm;
    logic [NPORT-1:0] mcStorm;
    logic [31:0] tickCnt;
    logic [NPORT-1:0] flowing;
    logic [NPORT-1:0] dropping;
    logic fwdValid;
    logic [NPORT-1:0] fwdMask;
    logic fwdDrop;
    logic [11:0] busAddr;
    logic busWrite;
    logic busPend;
    logic hreadyout;
    logic [31:0] hrdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic [19:0] clampAge(input logic [31:0] v);
    if (v < 32'(AGE_MIN)) return AGE_MIN;
    if (v > 32'(AGE_MAX)) return AGE_MAX;
    return v[19:0];
  endfunction : clampAge

  function automatic logic [15:0] clampFc(input logic [31:0] v);
    if (v < 32'(FC_THR_MIN)) return FC_THR_MIN;
    if (v > 32'(FC_THR_MAX)) return FC_THR_MAX;
    return v[15:0];
  endfunction : clampFc

  function automatic logic [25:0] stormLimit(input logic [15:0] kpps);
    return 26'(kpps * KPPS_SCALE);
  endfunction : stormLimit

  always_comb begin
    logic tick;
    logic isBc;
    logic isMc;
    logic hit;
    logic freeFound;
    logic [LW-1:0] slot;
    logic [NPORT-1:0] mask;
    logic drop;
    logic [31:0] rd;
    logic [11:0] a;
    int unsigned idx;
    int unsigned g;
    tick = 1'b0;
    isBc = 1'b0;
    isMc = 1'b0;
    hit = 1'b0;
    freeFound = 1'b0;
    slot = '0;
    mask = '0;
    drop = 1'b0;
    rd = '0;
    a = st_ff.busAddr;
    idx = 0;
    g = 0;
    nxt_st = st_ff;

    // One-second tick drives aging and closes each storm measuring window.
    if (st_ff.tickCnt >= TICK_LAST) begin
      nxt_st.tickCnt = '0;
      tick = 1'b1;
    end else begin
      nxt_st.tickCnt = st_ff.tickCnt + 32'd1;
    end

    for (int i = 0; i < NLRN; i++) begin
      if (tick && st_ff.lnValid[i]) begin
        if (st_ff.lnIdle[i] >= st_ff.ageTime) begin
          nxt_st.lnValid[i] = 1'b0; // see RQ3 see RQ19
        end else begin
          nxt_st.lnIdle[i] = st_ff.lnIdle[i] + 20'd1; // see RQ19
        end
      end
    end

    // Rate per port per class over the last second decides suppression.
    for (int p = 0; p < NPORT; p++) begin
      g = p / GSZ;
      if (tick) begin
        nxt_st.bcStorm[p] = st_ff.bcEn[g] && st_ff.bcCnt[p] > stormLimit(st_ff.stormThr[g]); // see RQ11
        nxt_st.mcStorm[p] = st_ff.mcEn[g] && st_ff.mcCnt[p] > stormLimit(st_ff.stormThr[g]); // see RQ11
        nxt_st.bcCnt[p] = '0;
        nxt_st.mcCnt[p] = '0;
      end else begin
        if (st_ff.bcEn[g] && st_ff.bcCnt[p] > stormLimit(st_ff.stormThr[g])) begin
          nxt_st.bcStorm[p] = 1'b1; // see RQ10 see RQ12
        end
        if (st_ff.mcEn[g] && st_ff.mcCnt[p] > stormLimit(st_ff.stormThr[g])) begin
          nxt_st.mcStorm[p] = 1'b1; // see RQ10 see RQ13
        end
      end
      if (!st_ff.bcEn[g]) begin
        nxt_st.bcStorm[p] = 1'b0; // see RQ13
      end
      if (!st_ff.mcEn[g]) begin
        nxt_st.mcStorm[p] = 1'b0; // see RQ13
      end
      nxt_st.flowing[p] = st_ff.fcEn[p] && portLoad[p*16 +: 16] >= st_ff.fcThr[p]; // see RQ14 see RQ15
      nxt_st.dropping[p] = st_ff.bcStorm[p] || st_ff.mcStorm[p]; // see RQ16
    end

    // Forwarding decision, one cycle after the header.
    nxt_st.fwdValid = frmValid;
    if (frmValid) begin
      isBc = frmDst == BCAST_MAC;
      isMc = frmDst[MCAST_BIT] && !isBc;
      mask = '1; // see RQ2
      if (isBc) begin
        drop = st_ff.bcStorm[frmPort]; // see RQ10
        // A header on the tick cycle opens the new window instead of being lost.
        if (tick) begin
          nxt_st.bcCnt[frmPort] = 26'd1;
        end else if (st_ff.bcCnt[frmPort] != '1) begin
          nxt_st.bcCnt[frmPort] = st_ff.bcCnt[frmPort] + 26'd1;
        end
      end else if (isMc) begin
        drop = st_ff.mcStorm[frmPort]; // see RQ10
        if (tick) begin
          nxt_st.mcCnt[frmPort] = 26'd1;
        end else if (st_ff.mcCnt[frmPort] != '1) begin
          nxt_st.mcCnt[frmPort] = st_ff.mcCnt[frmPort] + 26'd1;
        end
        for (int e = NMC - 1; e >= 0; e--) begin
          if (st_ff.mcValid[e] && st_ff.mcMac[e] == frmSrc && st_ff.mcVlan[e] == frmVlan) begin
            for (int p = 0; p < NPORT; p++) begin
              mask[p] = st_ff.mcState[e][p] == MEMBER_STATIC ||
                        (st_ff.mcState[e][p] == MEMBER_OPEN && st_ff.mcJoin[e][p]); // see RQ8 see RQ9
            end
          end
        end
      end else begin
        for (int i = NLRN - 1; i >= 0; i--) begin
          if (st_ff.lnValid[i] && st_ff.lnMac[i] == frmDst) begin
            mask = '0;
            mask[st_ff.lnPort[i]] = 1'b1; // see RQ1
          end
        end
        for (int u = NUC - 1; u >= 0; u--) begin
          if (st_ff.ucValid[u] && st_ff.ucMac[u] == frmDst && st_ff.ucVlan[u] == frmVlan) begin // see RQ6
            mask = '0;
            if (st_ff.ucDiscard[u] == DISCARD_ENTRY_TYPE) begin
              drop = 1'b1; // see RQ7
            end else begin
              mask[st_ff.ucPort[u]] = 1'b1; // see RQ7
            end
          end
        end
      end
      mask[frmPort] = 1'b0;
      if (drop) begin
        mask = '0;
      end
      nxt_st.fwdMask = mask;
      nxt_st.fwdDrop = drop;

      // Source learning: refresh a hit, else fill a free slot or the victim.
      if (!frmSrc[MCAST_BIT]) begin
        for (int i = NLRN - 1; i >= 0; i--) begin
          if (st_ff.lnValid[i] && st_ff.lnMac[i] == frmSrc) begin
            hit = 1'b1;
            slot = LW'(i);
          end
          if (!st_ff.lnValid[i]) begin
            freeFound = 1'b1;
            if (!hit) begin
              slot = LW'(i);
            end
          end
        end
        if (!hit && !freeFound) begin
          slot = st_ff.lnVictim;
          nxt_st.lnVictim = st_ff.lnVictim + LW'(1);
        end
        nxt_st.lnMac[slot] = frmSrc;
        nxt_st.lnPort[slot] = frmPort;
        nxt_st.lnIdle[slot] = '0; // see RQ19
        nxt_st.lnValid[slot] = 1'b1;
      end
    end else begin
      nxt_st.fwdMask = '0;
      nxt_st.fwdDrop = 1'b0;
    end

    // AHB-Lite slave: one wait cycle, then write takes effect and read data stands.
    nxt_st.hreadyout = 1'b1;
    if (st_ff.busPend) begin
      nxt_st.busPend = 1'b0;
      if (a == REG_AGE) begin
        rd = 32'(st_ff.ageTime);
        if (st_ff.busWrite) begin
          nxt_st.ageTime = clampAge(hwdata); // see RQ4
        end
      end else if (a == REG_STATUS) begin
        rd = 32'(st_ff.dropping) | (32'(st_ff.flowing) << STATUS_FLOW_LSB); // see RQ16
      end else if (a == REG_FC_EN) begin
        rd = 32'(st_ff.fcEn);
        if (st_ff.busWrite) begin
          nxt_st.fcEn = hwdata[NPORT-1:0];
        end
      end else if (a >= REG_STORM_BASE && a < REG_STORM_BASE + 12'(NGROUP * 4)) begin
        idx = 32'(a - REG_STORM_BASE) >> 2;
        rd = {14'h0, st_ff.mcEn[idx], st_ff.bcEn[idx], st_ff.stormThr[idx]};
        if (st_ff.busWrite) begin
          nxt_st.stormThr[idx] = hwdata[15:0]; // see RQ12
          nxt_st.bcEn[idx] = hwdata[STORM_BC_EN_BIT];
          nxt_st.mcEn[idx] = hwdata[STORM_MC_EN_BIT];
        end
      end else if (a >= REG_FC_THR_BASE && a < REG_FC_THR_BASE + 12'(NPORT * 4)) begin
        idx = 32'(a - REG_FC_THR_BASE) >> 2;
        rd = 32'(st_ff.fcThr[idx]);
        if (st_ff.busWrite) begin
          nxt_st.fcThr[idx] = clampFc(hwdata); // see RQ14
        end
      end else if (a >= REG_UC_BASE && a < REG_UC_BASE + 12'(NUC * 16)) begin
        idx = 32'(a - REG_UC_BASE) >> 4;
        case (a[3:2])
          2'h0: rd = st_ff.ucMac[idx][31:0];
          2'h1: rd = {st_ff.ucValid[idx], st_ff.ucDiscard[idx], 2'h0, st_ff.ucVlan[idx],
                      st_ff.ucMac[idx][47:32]};
          2'h2: rd = 32'(st_ff.ucPort[idx]);
          default: rd = '0;
        endcase
        if (st_ff.busWrite) begin
          case (a[3:2])
            2'h0: nxt_st.ucMac[idx][31:0] = hwdata;
            2'h1: begin
              nxt_st.ucMac[idx][47:32] = hwdata[15:0];
              nxt_st.ucVlan[idx] = hwdata[VLAN_LSB +: 12];
              nxt_st.ucDiscard[idx] = hwdata[UC_DISCARD_BIT]; // see RQ7
              nxt_st.ucValid[idx] = hwdata[ENTRY_VALID_BIT]; // see RQ20
            end
            2'h2: nxt_st.ucPort[idx] = hwdata[PW-1:0];
            default: ;
          endcase
        end
      end else if (a >= REG_MC_BASE && a < REG_MC_BASE + 12'(NMC * 16)) begin
        idx = 32'(a - REG_MC_BASE) >> 4;
        case (a[3:2])
          2'h0: rd = st_ff.mcMac[idx][31:0];
          2'h1: rd = {st_ff.mcValid[idx], 3'h0, st_ff.mcVlan[idx], st_ff.mcMac[idx][47:32]};
          2'h2: rd = 32'(st_ff.mcState[idx]);
          default: rd = 32'(st_ff.mcJoin[idx]);
        endcase
        if (st_ff.busWrite) begin
          case (a[3:2])
            2'h0: nxt_st.mcMac[idx][31:0] = hwdata;
            2'h1: begin
              nxt_st.mcMac[idx][47:32] = hwdata[15:0];
              nxt_st.mcVlan[idx] = hwdata[VLAN_LSB +: 12];
              nxt_st.mcValid[idx] = hwdata[ENTRY_VALID_BIT]; // see RQ20
            end
            2'h2: nxt_st.mcState[idx] = hwdata[2*NPORT-1:0]; // see RQ9
            default: nxt_st.mcJoin[idx] = hwdata[NPORT-1:0];
          endcase
        end
      end else if (a >= REG_TBL_BASE && a < REG_TBL_END) begin
        // Words 0..7 are two route entries, words 8..15 two ARP entries.
        idx = 32'(a - REG_TBL_BASE) >> 2;
        rd = st_ff.tbl[idx];
        if (st_ff.busWrite) begin
          nxt_st.tbl[idx] = hwdata; // see RQ18
          if (idx < NTBL / 2 && idx % 4 == 3) begin
            nxt_st.tbl[idx] = {hwdata[31], 27'h0, hwdata[3:0]};
            if (hwdata[3:0] < METRIC_MIN) begin
              nxt_st.tbl[idx][3:0] = METRIC_MIN; // see RQ17
            end
          end
        end
      end
      nxt_st.hrdata = rd;
    end else if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      nxt_st.busPend = 1'b1;
      nxt_st.busAddr = haddr[11:0];
      nxt_st.busWrite = hwrite;
      nxt_st.hreadyout = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.ageTime <= AGE_RESET; // see RQ5
      st_ff.stormThr <= {NGROUP{STORM_THR_RESET}};
      st_ff.fcThr <= {NPORT{FC_THR_RESET}};
      st_ff.hreadyout <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = st_ff.hreadyout;
  assign hrdata = st_ff.hrdata;
  assign hresp = 1'b0;
  assign fwdValid = st_ff.fwdValid;
  assign fwdMask = st_ff.fwdMask;
  assign fwdDrop = st_ff.fwdDrop;
  assign flowActive = st_ff.flowing;
  assign dropActive = st_ff.dropping;
endmodule : l2_l3_forwarding_filter

//--- verification/l2_l3_forwarding_filter_checker.sv
// Concurrent checks on the forwarding filter's ports.
// Assumes hready is tied to hreadyout by the bench.
`timescale 1ns/1ps
module l2_l3_forwarding_filter_checker
  import fwd_filter_pkg::*;
#(
  parameter int unsigned NPORT = 8
) (
  input wire logic mclk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hready, // Bus ready.
  input wire logic hreadyout, // Slave ready.
  input wire logic hresp, // Response.
  input wire logic frmValid, // Header strobe.
  input wire logic [$clog2(NPORT)-1:0] frmPort, // Ingress port.
  input wire logic [47:0] frmDst, // Destination MAC.
  input wire logic [NPORT*16-1:0] portLoad, // Held traffic.
  input wire logic fwdValid, // Decision strobe.
  input wire logic [NPORT-1:0] fwdMask, // Egress ports.
  input wire logic fwdDrop, // Discard.
  input wire logic [NPORT-1:0] flowActive // Flow control.
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  fwd_follows_a: assert property (frmValid |=> fwdValid)
    else $error("decision missing after header");
  fwd_quiet_a: assert property (!frmValid |=> !fwdValid && fwdMask == '0)
    else $error("decision without header");
  bcast_flood_a: assert property (frmValid && frmDst == BCAST_MAC |=>
    fwdDrop || fwdMask == ~(NPORT'(1) << $past(frmPort)))
    else $error("broadcast not flooded");
  drop_empty_a: assert property (fwdDrop |-> fwdValid && fwdMask == '0)
    else $error("dropped frame has egress ports");
  flow_load_a: assert property (flowActive[1] |-> $past(portLoad[31:16]) >= FC_THR_MIN)
    else $error("flow control below minimum load");
  bus_wait_a: assert property (hsel && hready && htrans == HTRANS_NONSEQ && hreadyout
    |=> !hreadyout ##1 hreadyout)
    else $error("data phase not two cycles");
  bus_low_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule : l2_l3_forwarding_filter_checker

bind l2_l3_forwarding_filter l2_l3_forwarding_filter_checker #(.NPORT(NPORT)) u_checker (
  .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .frmValid(frmValid), .frmPort(frmPort),
  .frmDst(frmDst), .portLoad(portLoad), .fwdValid(fwdValid), .fwdMask(fwdMask),
  .fwdDrop(fwdDrop), .flowActive(flowActive));

//--- verification/fwd_station_model.sv
// Stations on the ports: send frame headers and set the traffic held per port.
// Assumes calls start just after a rising edge of mclk.
`timescale 1ns/1ps
module fwd_station_model #(
  parameter int unsigned NPORT = 8
) (
  input wire logic mclk, // Clock.
  output logic frmValid, // Header strobe.
  output logic [$clog2(NPORT)-1:0] frmPort, // Ingress port.
  output logic [47:0] frmDst, // Destination MAC.
  output logic [47:0] frmSrc, // Source MAC.
  output logic [11:0] frmVlan, // VLAN.
  output logic [NPORT*16-1:0] portLoad, // Held traffic.
  input wire logic fwdValid, // Decision strobe.
  input wire logic [NPORT-1:0] fwdMask, // Egress ports.
  input wire logic fwdDrop // Discard.
);
  initial begin
    frmValid = 1'b0;
    frmPort = '0;
    frmDst = '0;
    frmSrc = '0;
    frmVlan = '0;
    portLoad = '0;
  end
  // Fields are inverted once the strobe drops, so stale values never match.
  task automatic sendFrame(input logic [$clog2(NPORT)-1:0] p, input logic [47:0] d, s,
                           input logic [11:0] v, output logic [NPORT+1:0] res);
    frmValid <= 1'b1;
    frmPort <= p;
    frmDst <= d;
    frmSrc <= s;
    frmVlan <= v;
    @(posedge mclk);
    frmValid <= 1'b0;
    frmPort <= ~p;
    frmDst <= ~d;
    frmSrc <= ~s;
    frmVlan <= ~v;
    @(negedge mclk);
    res = {fwdValid, fwdDrop, fwdMask};
    @(posedge mclk);
  endtask : sendFrame
  task automatic setLoad(input int p, input logic [15:0] n);
    portLoad[p*16+:16] <= n;
  endtask : setLoad
endmodule : fwd_station_model

//--- verification/l2_l3_forwarding_filter_bench.sv
// Self-checking bench: register bus, lookups, aging, flow control, tables.
// Assumes the station model and the bound checker.
`timescale 1ns/1ps
module l2_l3_forwarding_filter_bench;
  import fwd_filter_pkg::*;
  localparam int unsigned TICK = 100;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, frmValid, fwdValid, fwdDrop;
  logic [31:0] hrdata, rd;
  logic [2:0] frmPort;
  logic [47:0] frmDst, frmSrc;
  logic [11:0] frmVlan;
  logic [127:0] portLoad;
  logic [7:0] fwdMask, flowActive, dropActive;
  logic [9:0] fr;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #5 mclk = ~mclk;
  l2_l3_forwarding_filter #(.TICK_LEN(TICK)) u_l2_l3_forwarding_filter (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .frmValid(frmValid),
    .frmPort(frmPort), .frmDst(frmDst), .frmSrc(frmSrc), .frmVlan(frmVlan),
    .portLoad(portLoad), .fwdValid(fwdValid), .fwdMask(fwdMask), .fwdDrop(fwdDrop),
    .flowActive(flowActive), .dropActive(dropActive));
  fwd_station_model u_fwd_station_model (
    .mclk(mclk), .frmValid(frmValid), .frmPort(frmPort), .frmDst(frmDst),
    .frmSrc(frmSrc), .frmVlan(frmVlan), .portLoad(portLoad), .fwdValid(fwdValid),
    .fwdMask(fwdMask), .fwdDrop(fwdDrop));
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic checkWord(input string name, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : checkWord
  task automatic checkFwd(input string name, input logic [9:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : checkFwd
  // Ready is judged at the falling edge so the next rising edge acts on it.
  task automatic waitReady;
    @(negedge mclk);
    while (hreadyout !== 1'b1) @(negedge mclk);
    rd = hrdata;
    @(posedge mclk);
  endtask : waitReady
  task automatic busXfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    waitReady();
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
  endtask : busXfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    busXfer(1'b1, a, d);
  endtask : wr
  task automatic rdChk(input string name, input logic [11:0] a, input logic [31:0] exp);
    busXfer(1'b0, a, 32'h0);
    checkWord(name, exp, rd);
  endtask : rdChk
  task automatic frm(input string name, input logic [2:0] p, input logic [47:0] d, s,
                     input logic [11:0] v, input logic [9:0] exp);
    u_fwd_station_model.sendFrame(p, d, s, v, fr);
    checkFwd(name, exp, fr);
  endtask : frm
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdChk("age reset", REG_AGE, 32'h12C);
    rdChk("fc thr reset", REG_FC_THR_BASE, 32'hE000);
    wr(12'h200, 32'h12345678);
    rdChk("unmapped", 12'h200, 32'h0);
    rdChk("status reset", REG_STATUS, 32'h0);
    wr(REG_AGE, 32'h64);
    rdChk("age low", REG_AGE, 32'h12C);
    wr(REG_AGE, 32'h1E8480);
    rdChk("age high", REG_AGE, 32'hF4240);
    wr(REG_AGE, 32'h12C);
    $display("Test registers done");
    wr(REG_UC_BASE, 32'h000000C0);
    wr(REG_UC_BASE + 12'h4, 32'h80050200);
    wr(REG_UC_BASE + 12'h8, 32'h3);
    wr(REG_UC_BASE + 12'h10, 32'h000000D0);
    wr(REG_UC_BASE + 12'h14, 32'hC0050200);
    wr(REG_UC_BASE + 12'h18, 32'h1);
    frm("static fwd", 3'h0, 48'h0200000000C0, 48'h020000000010, 12'h5, 10'h208);
    frm("other vlan", 3'h0, 48'h0200000000C0, 48'h020000000010, 12'h6, 10'h2FE);
    frm("discard", 3'h0, 48'h0200000000D0, 48'h020000000010, 12'h5, 10'h300);
    frm("unknown", 3'h2, 48'h020000000FFF, 48'h0200000000A0, 12'h1, 10'h2FB);
    frm("learned", 3'h5, 48'h0200000000A0, 48'h0200000000B0, 12'h1, 10'h204);
    wr(REG_STORM_BASE, 32'h00010001);
    frm("bcast below", 3'h1, BCAST_MAC, 48'h020000000011, 12'h1, 10'h2FD);
    $display("Test lookup done");
    wr(REG_MC_BASE, 32'h000000E0);
    wr(REG_MC_BASE + 12'h4, 32'h80070200);
    wr(REG_MC_BASE + 12'h8, 32'h00000024);
    wr(REG_MC_BASE + 12'hC, 32'h0000000C);
    frm("mcast", 3'h0, 48'h01005E000001, 48'h0200000000E0, 12'h7, 10'h20A);
    $display("Test multicast done");
    repeat (303 * TICK) @(posedge mclk);
    frm("aged", 3'h5, 48'h0200000000A0, 48'h0200000000B0, 12'h1, 10'h2DF);
    frm("static kept", 3'h0, 48'h0200000000C0, 48'h020000000010, 12'h5, 10'h208);
    $display("Test aging done");
    // Threshold zero: two warm-up broadcasts arm the storm flag whatever the tick phase.
    wr(REG_STORM_BASE, 32'h00010000);
    u_fwd_station_model.sendFrame(3'h1, BCAST_MAC, 48'h020000000011, 12'h1, fr);
    u_fwd_station_model.sendFrame(3'h1, BCAST_MAC, 48'h020000000011, 12'h1, fr);
    frm("bcast storm", 3'h1, BCAST_MAC, 48'h020000000011, 12'h1, 10'h300);
    rdChk("storm status", REG_STATUS, 32'h2);
    checkWord("dropActive", 32'h2, {24'h0, dropActive});
    frm("mcast free", 3'h0, 48'h01005E000001, 48'h0200000000E0, 12'h7, 10'h20A);
    repeat (2 * TICK + 4) @(posedge mclk);
    frm("bcast resumed", 3'h1, BCAST_MAC, 48'h020000000011, 12'h1, 10'h2FD);
    wr(REG_STORM_BASE, 32'h00000001);
    $display("Test storm done");
    wr(REG_FC_THR_BASE + 12'h4, 32'h1);
    rdChk("fc thr low", REG_FC_THR_BASE + 12'h4, 32'h2);
    wr(REG_FC_THR_BASE + 12'h4, 32'hEA60);
    rdChk("fc thr high", REG_FC_THR_BASE + 12'h4, 32'hE000);
    wr(REG_FC_THR_BASE + 12'h4, 32'hA);
    u_fwd_station_model.setLoad(1, 16'hA);
    rdChk("fc disabled", REG_STATUS, 32'h0);
    wr(REG_FC_EN, 32'h2);
    rdChk("fc status", REG_STATUS, 32'h00020000);
    checkWord("flowActive", 32'h2, {24'h0, flowActive});
    u_fwd_station_model.setLoad(1, 16'h9);
    rdChk("fc below", REG_STATUS, 32'h0);
    $display("Test flow control done");
    wr(REG_TBL_BASE, 32'hC0A80001);
    rdChk("route ip", REG_TBL_BASE, 32'hC0A80001);
    wr(REG_TBL_BASE + 12'hC, 32'h80000000);
    rdChk("metric min", REG_TBL_BASE + 12'hC, 32'h80000001);
    wr(12'h128, 32'h80030200);
    rdChk("arp word", 12'h128, 32'h80030200);
    $display("Test tables done");
    give_verdict();
  end
endmodule : l2_l3_forwarding_filter_bench
